/* File: hw/ecap_pkg.sv */
// constants, types and helpers of the enhanced controller capability register bank
//
// Operation
// - capability words sit at the start of the function space, before operational ones
// - offset zero holds the length-and-version word, four bytes, read only
// - bits 31 to 16 of word zero carry the interface version in BCD
// - bits 7 to 0 of word zero give the offset to operational registers
// - structural parameters word sits at offset 04h, read only
// - structural bits 23 to 20 name the root port used as debug port
// - debug port number is nonzero only when a debug port exists
// - debug port number never exceeds the reported downstream port count
// - bit 16 set means each port register has a writable indicator field
// - port indicator support bit follows amber strap level sampled during reset
// - bits 3 to 0 give downstream port count, valid 1h to Fh
// - bits 15 to 12 give companion count; zero means high-speed only
// - bit 7 picks routing: 0 grouped by function order, 1 explicit array
// - bit 4 shows port power switches and steers port power control
package ecap_pkg;

	// ****************************************
	// bus geometry and offsets
	// ****************************************
	localparam int          ADDR_W            = 8;
	localparam int          DATA_W            = 32;
	localparam int          WORD_IDX_W        = ADDR_W - 2;
	localparam logic [7:0]  OFS_LEN_VERSION   = 8'h00;
	localparam logic [7:0]  OFS_STRUCT_PARAMS = 8'h04;
	localparam logic [7:0]  CAP_SPACE_LENGTH  = 8'h20;

	// ****************************************
	// field positions
	// ****************************************
	localparam int VERSION_LSB   = 16;
	localparam int LENGTH_LSB    = 0;
	localparam int DEBUG_LSB     = 20;
	localparam int INDICATOR_BIT = 16;
	localparam int COMPANION_LSB = 12;
	localparam int PER_COMP_LSB  = 8;
	localparam int ROUTING_BIT   = 7;
	localparam int POWER_SW_BIT  = 4;
	localparam int PORTS_LSB     = 0;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [15:0] INTERFACE_VERSION_BCD = 16'h0100;
	localparam logic [3:0]  DEBUG_PORT_RST        = 4'h0;
	localparam logic [3:0]  COMPANION_RST         = 4'h2;
	localparam logic [3:0]  PER_COMPANION_RST     = 4'h2;
	localparam logic        ROUTING_RST           = 1'b1;
	localparam logic        POWER_SW_RST          = 1'b1;
	localparam logic [3:0]  PORTS_RST             = 4'h4;
	localparam logic [31:0] STRUCT_PARAMS_RST     = 32'h00002294;

	// cycles of internal reset hold during which the strap is sampled
	localparam logic [1:0]  STRAP_HOLD_CYCLES     = 2'h2;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ecap_req_s;

	typedef struct packed {
		logic [3:0] debug_port_number;
		logic       port_indicator_support;
		logic [3:0] companion_controller_count;
		logic [3:0] ports_per_companion;
		logic       port_routing_rule;
		logic       port_power_switch_present;
		logic [3:0] port_count;
	} ecap_struct_s;

	typedef enum logic [1:0] {
		ST_HOLD,
		ST_CHECK,
		ST_READY
	} ecap_state_e;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] pack_struct(input ecap_struct_s f);
		logic [31:0] w;
		w = 32'h00000000;
		w[DEBUG_LSB +: 4]     = f.debug_port_number;
		w[INDICATOR_BIT]      = f.port_indicator_support;
		w[COMPANION_LSB +: 4] = f.companion_controller_count;
		w[PER_COMP_LSB +: 4]  = f.ports_per_companion;
		w[ROUTING_BIT]        = f.port_routing_rule;
		w[POWER_SW_BIT]       = f.port_power_switch_present;
		w[PORTS_LSB +: 4]     = f.port_count;
		return w;
	endfunction

	function automatic logic [31:0] pack_len_version(input logic [7:0] len);
		logic [31:0] w;
		w = 32'h00000000;
		w[VERSION_LSB +: 16] = INTERFACE_VERSION_BCD;
		w[LENGTH_LSB +: 8]   = len;
		return w;
	endfunction

endpackage

/* File: hw/ecap_strap.sv */
// strap sampler: holds an internal reset and samples the amber strap during it
`timescale 1ns/1ps
`default_nettype none
module ecap_strap
	import ecap_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_nrst,
	input  wire logic i_strap,
	output logic      o_level,
	output logic      o_done
);

	logic [1:0] hold_cnt;

	// ****************************************
	// internal reset hold
	// ****************************************
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			hold_cnt <= 2'h0;
		else if (hold_cnt != STRAP_HOLD_CYCLES)
			hold_cnt <= hold_cnt + 2'h1;
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_done <= 1'b0;
		else
			o_done <= (hold_cnt == STRAP_HOLD_CYCLES);
	end

	// ****************************************
	// strap capture, frozen once hold ends
	// ****************************************
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_level <= 1'b0;
		else if (hold_cnt != STRAP_HOLD_CYCLES)
			o_level <= i_strap;
	end

endmodule
`default_nettype wire

/* File: hw/ecap_regs.sv */
// capability register bank of the enhanced host controller function
`timescale 1ns/1ps
`default_nettype none
module ecap_regs
(
	input  wire logic                  I_CLK_SYS,
	input  wire logic                  I_NRST,
	input  wire ecap_pkg::ecap_req_s   I_REQ,
	input  wire logic                  I_AMBER_INDICATOR_STRAP_PIN,
	output logic [ecap_pkg::DATA_W-1:0] O_RDATA,
	output logic                       O_ACK,
	output logic                       O_WRITE_IGNORED,
	output logic                       O_UNMAPPED,
	output logic                       O_READY,
	output logic                       O_CONFIG_ERROR,
	output logic [7:0]                 O_OP_BASE,
	output ecap_pkg::ecap_struct_s     O_STRUCT
);
	import ecap_pkg::*;

	// ****************************************
	// declarations
	// ****************************************
	ecap_state_e               state;
	ecap_state_e               next_state;
	ecap_struct_s              fields;
	ecap_struct_s              next_fields;
	logic                      strap_level;
	logic                      strap_done;
	logic                      fields_ok;
	logic [WORD_IDX_W-1:0]     word_idx;
	logic                      hit_len;
	logic                      hit_struct;
	logic                      in_cap_space;
	logic                      access;
	logic [DATA_W-1:0]         next_rdata;
	logic [31:0]               struct_word;
	logic [31:0]               len_word;

	// ****************************************
	// strap sampler
	// ****************************************
	ecap_strap u_strap
	(
		.i_clk   (I_CLK_SYS),
		.i_nrst  (I_NRST),
		.i_strap (I_AMBER_INDICATOR_STRAP_PIN),
		.o_level (strap_level),
		.o_done  (strap_done)
	);

	// ****************************************
	// structural fields at capture
	// ****************************************
	always_comb
	begin
		next_fields                            = fields;
		next_fields.port_count                 = PORTS_RST;
		next_fields.companion_controller_count = COMPANION_RST;
		next_fields.ports_per_companion        = PER_COMPANION_RST;
		next_fields.port_routing_rule          = ROUTING_RST;
		next_fields.port_power_switch_present  = POWER_SW_RST;
		next_fields.port_indicator_support     = strap_level;
		// no debug port unless the number is nonzero and in range
		if (DEBUG_PORT_RST != 4'h0 && DEBUG_PORT_RST <= PORTS_RST)
			next_fields.debug_port_number = DEBUG_PORT_RST;
		else
			next_fields.debug_port_number = 4'h0;
	end

	// ****************************************
	// consistency check of captured fields
	// ****************************************
	always_comb
	begin
		fields_ok = 1'b1;
		if (fields.port_count == 4'h0)
			fields_ok = 1'b0;
		if (fields.debug_port_number > fields.port_count)
			fields_ok = 1'b0;
		if (fields.companion_controller_count != 4'h0
			&& ({4'h0, fields.companion_controller_count} * {4'h0, fields.ports_per_companion})
			< {4'h0, fields.port_count})
			fields_ok = 1'b0;
	end

	// ****************************************
	// bring-up sequence
	// ****************************************
	always_comb
	begin
		next_state = state;
		case (state)
			ST_HOLD:
			begin
				if (strap_done)
					next_state = ST_CHECK;
			end
			ST_CHECK:
			begin
				next_state = ST_READY;
			end
			ST_READY:
			begin
				next_state = ST_READY;
			end
			default:
			begin
				next_state = ST_HOLD;
			end
		endcase
	end

	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
			state <= ST_HOLD;
		else
			state <= next_state;
	end

	// fields load only while held, then stay frozen until the next reset
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			fields.debug_port_number          <= DEBUG_PORT_RST;
			fields.port_indicator_support     <= 1'b0;
			fields.companion_controller_count <= COMPANION_RST;
			fields.ports_per_companion        <= PER_COMPANION_RST;
			fields.port_routing_rule          <= ROUTING_RST;
			fields.port_power_switch_present  <= POWER_SW_RST;
			fields.port_count                 <= PORTS_RST;
		end
		else if (state == ST_HOLD)
			fields <= next_fields;
	end

	// ****************************************
	// status outputs
	// ****************************************
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
			O_READY <= 1'b0;
		else
			O_READY <= (state == ST_READY);
	end

	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
			O_CONFIG_ERROR <= 1'b0;
		else if (state == ST_CHECK)
			O_CONFIG_ERROR <= !fields_ok;
	end

	// port logic sees the same values that software reads
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			O_STRUCT.debug_port_number          <= DEBUG_PORT_RST;
			O_STRUCT.port_indicator_support     <= 1'b0;
			O_STRUCT.companion_controller_count <= COMPANION_RST;
			O_STRUCT.ports_per_companion        <= PER_COMPANION_RST;
			O_STRUCT.port_routing_rule          <= ROUTING_RST;
			O_STRUCT.port_power_switch_present  <= POWER_SW_RST;
			O_STRUCT.port_count                 <= PORTS_RST;
		end
		else
			O_STRUCT <= fields;
	end

	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
			O_OP_BASE <= CAP_SPACE_LENGTH;
		else
			O_OP_BASE <= CAP_SPACE_LENGTH;
	end

	// ****************************************
	// address decode
	// ****************************************
	assign word_idx     = I_REQ.addr[ADDR_W-1:2];
	assign hit_len      = (word_idx == OFS_LEN_VERSION[ADDR_W-1:2]);
	assign hit_struct   = (word_idx == OFS_STRUCT_PARAMS[ADDR_W-1:2]);
	assign in_cap_space = (I_REQ.addr < CAP_SPACE_LENGTH);
	assign access       = I_REQ.rd || I_REQ.wr;
	assign len_word     = pack_len_version(CAP_SPACE_LENGTH);
	assign struct_word  = pack_struct(fields);

	// ****************************************
	// read data
	// ****************************************
	always_comb
	begin
		next_rdata = 32'h00000000;
		if (I_REQ.rd)
		begin
			if (hit_len)
				next_rdata = len_word;
			else if (hit_struct)
				next_rdata = struct_word;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
			O_RDATA <= 32'h00000000;
		else if (I_REQ.rd)
			O_RDATA <= next_rdata;
	end

	// ****************************************
	// handshake and access flags
	// ****************************************
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
			O_ACK <= 1'b0;
		else
			O_ACK <= access;
	end

	// writes never change a field
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
			O_WRITE_IGNORED <= 1'b0;
		else
			O_WRITE_IGNORED <= I_REQ.wr && !I_REQ.rd;
	end

	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
			O_UNMAPPED <= 1'b0;
		else
			O_UNMAPPED <= access && !(in_cap_space && (hit_len || hit_struct));
	end

endmodule
`default_nettype wire

/* File: verif/ecap_regs_props.sv */
// assertion checker for the capability register bank
`timescale 1ns/1ps
`default_nettype none
module ecap_regs_props
	import ecap_pkg::*;
(
	input wire logic                    I_CLK_SYS,
	input wire logic                    I_NRST,
	input wire ecap_pkg::ecap_req_s     I_REQ,
	input wire logic                    I_AMBER_INDICATOR_STRAP_PIN,
	input wire logic [ecap_pkg::DATA_W-1:0] O_RDATA,
	input wire logic                    O_ACK,
	input wire logic                    O_WRITE_IGNORED,
	input wire logic                    O_UNMAPPED,
	input wire logic                    O_READY,
	input wire logic                    O_CONFIG_ERROR,
	input wire logic [7:0]              O_OP_BASE,
	input wire ecap_pkg::ecap_struct_s  O_STRUCT
);
	// ****************************************
	// edges since release, strap copy
	// ****************************************
	logic [2:0] cnt;
	logic       cap;
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
			cnt <= 3'h0;
		else if (cnt != 3'h7)
			cnt <= cnt + 3'h1;
	end
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
			cap <= 1'b0;
		else if (cnt == 3'h1)
			cap <= I_AMBER_INDICATOR_STRAP_PIN;
	end
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_NRST);
	// ****************************************
	// assertions
	// ****************************************
	a_ack_after_req: assert property ((I_REQ.rd || I_REQ.wr) |=> O_ACK)
		else $error("no acknowledge one cycle after request");
	a_word0_value: assert property ((I_REQ.rd && I_REQ.addr[7:2] == 6'h00) |=> O_RDATA == 32'h01000020)
		else $error("length and version word wrong");
	a_word1_value: assert property ((I_REQ.rd && I_REQ.addr[7:2] == 6'h01 && O_READY)
		|=> O_RDATA == (32'h00002294 | {15'h0000, cap, 16'h0000}))
		else $error("structural word wrong");
	a_write_flagged: assert property ((I_REQ.wr && !I_REQ.rd) |=> O_WRITE_IGNORED && O_ACK)
		else $error("write not flagged as ignored");
	a_unmapped_zero: assert property ((I_REQ.rd && I_REQ.addr[7:3] != 5'h00) |=> O_UNMAPPED && O_RDATA == 32'h0)
		else $error("unmapped read not zero");
	a_struct_frozen: assert property (O_READY |=> $stable(O_STRUCT) && O_READY)
		else $error("structural fields moved after bring-up");
	a_debug_in_range: assert property (O_READY |-> O_STRUCT.debug_port_number <= O_STRUCT.port_count
		&& O_STRUCT.port_count != 4'h0)
		else $error("debug port or port count out of range");
	a_strap_kept: assert property (O_READY |-> O_STRUCT.port_indicator_support == cap)
		else $error("indicator support differs from strap");
	a_ready_bound: assert property (cnt == 3'h7 |-> O_READY && O_OP_BASE == 8'h20)
		else $error("not ready in time or bad operational base");
	c_read0: cover property (I_REQ.rd && I_REQ.addr == 8'h00);
	c_write: cover property (I_REQ.wr ##1 O_WRITE_IGNORED);
	c_unmap: cover property (O_UNMAPPED);
	c_strap: cover property (O_READY && O_STRUCT.port_indicator_support);
endmodule
bind ecap_regs ecap_regs_props ecap_regs_props_i (.I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .I_REQ(I_REQ),
	.I_AMBER_INDICATOR_STRAP_PIN(I_AMBER_INDICATOR_STRAP_PIN), .O_RDATA(O_RDATA), .O_ACK(O_ACK),
	.O_WRITE_IGNORED(O_WRITE_IGNORED), .O_UNMAPPED(O_UNMAPPED), .O_READY(O_READY),
	.O_CONFIG_ERROR(O_CONFIG_ERROR), .O_OP_BASE(O_OP_BASE), .O_STRUCT(O_STRUCT));
`default_nettype wire

/* File: verif/ecap_regs_tb.sv */
// self-checking bench of the capability register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
	$display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module ecap_regs_tb;
	import ecap_pkg::*;
	logic         clk = 1'b0;
	logic         nrst = 1'b0;
	ecap_req_s    req = '0;
	logic         strap = 1'b0;
	logic [31:0]  rdata;
	logic         ack;
	logic         wign;
	logic         unm;
	logic         ready;
	logic         cfg_err;
	logic [7:0]   op_base;
	ecap_struct_s strct;
	logic [31:0]  exp_w1;
	logic         boot_strap;
	int           failures = 0;
	int           cmp_count = 0;
	always #20 clk = ~clk;
	ecap_regs ecap_regs_i (.I_CLK_SYS(clk), .I_NRST(nrst), .I_REQ(req), .I_AMBER_INDICATOR_STRAP_PIN(strap),
		.O_RDATA(rdata), .O_ACK(ack), .O_WRITE_IGNORED(wign), .O_UNMAPPED(unm), .O_READY(ready),
		.O_CONFIG_ERROR(cfg_err), .O_OP_BASE(op_base), .O_STRUCT(strct));
	// ****************************************
	// bus helpers
	// ****************************************
	task automatic access(input logic r, input logic w, input logic [7:0] a);
		@(posedge clk);
		#1;
		req = '{rd: r, wr: w, addr: a, wdata: 32'hffffffff};
		@(posedge clk);
		#1;
		req = '0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic u);
		access(1'b1, 1'b0, a);
		`CHK(ack, 1'b1)
		`CHK(rdata, e)
		`CHK(unm, u)
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_boot(input logic s);
		@(posedge clk);
		#1;
		nrst = 1'b0;
		strap = s;
		boot_strap = s;
		exp_w1 = 32'h00002294 | {15'h0000, s, 16'h0000};
		repeat (4) @(posedge clk);
		#1;
		`CHK(op_base, 8'h20)
		`CHK(ack, 1'b0)
		nrst = 1'b1;
		for (int i = 0; i < 20 && ready !== 1'b1; i++)
			@(posedge clk);
		#1;
		`CHK(ready, 1'b1)
		strap = ~s;
		`CHK(cfg_err, 1'b0)
	endtask
	task automatic t_fields;
		`CHK(strct, {4'h0, boot_strap, 4'h2, 4'h2, 1'b1, 1'b1, 4'h4})
	endtask
	task automatic t_words;
		rd_chk(8'h00, 32'h01000020, 1'b0);
		rd_chk(8'h03, 32'h01000020, 1'b0);
		rd_chk(8'h04, exp_w1, 1'b0);
	endtask
	task automatic t_b2b;
		@(posedge clk);
		#1;
		req = '{rd: 1'b1, wr: 1'b0, addr: 8'h00, wdata: 32'h0};
		@(posedge clk);
		#1;
		req.addr = 8'h04;
		`CHK(rdata, 32'h01000020)
		`CHK(ack, 1'b1)
		@(posedge clk);
		#1;
		req = '0;
		`CHK(rdata, exp_w1)
		`CHK(ack, 1'b1)
		@(posedge clk);
		#1;
		`CHK(ack, 1'b0)
	endtask
	task automatic t_writes;
		rd_chk(8'h04, exp_w1, 1'b0);
		access(1'b0, 1'b1, 8'h00);
		`CHK(wign, 1'b1)
		`CHK(rdata, exp_w1)
		access(1'b0, 1'b1, 8'h04);
		`CHK(wign, 1'b1)
		rd_chk(8'h00, 32'h01000020, 1'b0);
		rd_chk(8'h04, exp_w1, 1'b0);
	endtask
	task automatic t_unmapped;
		logic [7:0] addrs [4];
		addrs = '{8'h08, 8'h0c, 8'h1c, 8'hfc};
		foreach (addrs[i])
			rd_chk(addrs[i], 32'h0, 1'b1);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial
	begin
		t_boot(1'b0);
		t_fields();
		t_words();
		t_b2b();
		t_writes();
		t_unmapped();
		t_boot(1'b1);
		t_fields();
		t_words();
		tally_and_finish();
	end
	initial
	begin
		#80000;
		failures++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
